// *** hdl/csc_defines.vh ***
// Constants for the command status checker: completion codes, APB map, command fields.
// Assumes inclusion by bare name from the design file.
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH
// ----------------------------------------
// Completion codes
// ----------------------------------------
`define CSC_GOOD 8'h00
`define CSC_QFULL 8'h01
`define CSC_WQ_INIT_ERR 8'h02
`define CSC_FIRST_CMD 8'h03
`define CSC_CMD_CODE 8'h04
`define CSC_QNUM 8'h05
`define CSC_Q_ALREADY 8'h06
`define CSC_Q_UNINIT 8'h07
`define CSC_QMODE_NRDY 8'h08
`define CSC_CMD_UNAVAIL 8'h09
`define CSC_BURST 8'h0B
`define CSC_RESV 8'h10
`define CSC_RST_DONE 8'h11
`define CSC_PORT1_NA 8'h12
`define CSC_ID_ERR 8'h13
`define CSC_BUS_IN_RST 8'h14
`define CSC_ABORT_RST 8'h15
`define CSC_TAG_ZERO 8'h17
`define CSC_TAG_BUSY 8'h18
`define CSC_DMA_BERR 8'h20
`define CSC_ACQ_TMO 8'h21
`define CSC_ADDR_ALIGN 8'h23
`define CSC_MEMTYPE 8'h24
`define CSC_ODD_COUNT 8'h25
`define CSC_FETCH_BERR 8'h26
`define CSC_FETCH_TMO 8'h27
`define CSC_POST_BERR 8'h28
`define CSC_POST_TMO 8'h29
`define CSC_FETCH_ADDR 8'h2A
`define CSC_POST_ADDR 8'h2B
`define CSC_SG_BERR 8'h2C
`define CSC_SG_TMO 8'h2D
`define CSC_SG_COUNT 8'h2E
`define CSC_SEL_TMO 8'h30
`define CSC_DISC_TMO 8'h31
`define CSC_ABN_SEQ 8'h32
`define CSC_DISC_ERR 8'h33
`define CSC_XFER_CNT 8'h34
`define CSC_PARITY 8'h35
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSC_A_CMD 12'h000
`define CSC_A_OPT 12'h004
`define CSC_A_ADDR 12'h008
`define CSC_A_COUNT 12'h00C
`define CSC_A_SG 12'h010
`define CSC_A_CFG 12'h014
`define CSC_A_EXEC 12'h018
`define CSC_A_GO 12'h01C
`define CSC_A_STAT 12'h020
`define CSC_A_QSTAT 12'h024
`define CSC_A_XFER 12'h028
// ----------------------------------------
// CMD register fields
// ----------------------------------------
`define CSC_CMD_OP 7:0
`define CSC_CMD_TYPE 9:8
`define CSC_CMD_QNUM 15:12
`define CSC_CMD_TGT 18:16
`define CSC_CMD_PORT 19
`define CSC_CMD_RESV 23:20
`define CSC_TYPE_SCSI 2'h1
`define CSC_TYPE_CTRL 2'h2
`define CSC_OP_INIT_CTRL 8'h41
`define CSC_OP_INIT_WQ 8'h42
`define CSC_OP_BUS_RST 8'h22
`define CSC_OP_TAG_SRCH 8'h45
`define CSC_OP_FLUSH 8'h46
`define CSC_OP_SCSI 8'h20
`define CSC_OP_SCSI_SG 8'h21
`define CSC_OP_COMPLETE 8'h47
// ----------------------------------------
// OPT register fields
// ----------------------------------------
`define CSC_OPT_REINIT 0
`define CSC_OPT_START_QM 1
`define CSC_OPT_W32 2
`define CSC_OPT_MEMTYPE 7:4
`define CSC_OPT_BURST 24:16
`define CSC_OPT_TAG 31:28
`define CSC_MAX_BURST 9'h100
`define CSC_MAX_MEMTYPE 4'h3
// ----------------------------------------
// CFG and EXEC fields, SG count limit
// ----------------------------------------
`define CSC_CFG_OWN_ID 2:0
`define CSC_CFG_PORT1 3
`define CSC_CFG_POST_BAD 4
`define CSC_SG_MAX 8'h40
`define CSC_EXEC_BITS 15
`endif

// *** hdl/csc_checker.v ***
// Command status checker: validates a queued parameter block and picks its completion code.
// Assumes an APB master and an external execution engine reporting outcomes via EXEC register.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "csc_defines.vh"

module csc_checker #(
  parameter QDEPTH = 4,
  parameter NQUEUE = 15
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg scsi_bus_reset
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] cmd;
  reg [31:0] opt;
  reg [31:0] buf_addr;
  reg [31:0] max_count;
  reg [7:0] sg_count;
  reg [4:0] cfg;
  reg [31:0] exec;
  reg [7:0] code;
  reg [7:0] pass_back;
  reg done;
  reg ctrl_init;
  reg seen_first;
  reg [NQUEUE-1:0] q_init;
  reg [2:0] q_used [0:NQUEUE-1];
  reg [3:0] active_tag;
  reg active_valid;
  reg [7:0] next_code;
  integer i;

  wire apb_wr = psel & penable & pwrite & pready;
  // Read data is loaded in the setup cycle so it stands when pready is sampled
  wire apb_rd = psel & ~penable & ~pwrite;
  wire go = apb_wr && (paddr == `CSC_A_GO);
  wire [7:0] op = cmd[`CSC_CMD_OP];
  wire [1:0] ctype = cmd[`CSC_CMD_TYPE];
  wire [3:0] qn = cmd[`CSC_CMD_QNUM];
  wire qok = (qn < NQUEUE);
  wire [3:0] qsel = qok ? qn : 4'h0;
  wire q_is_init = q_init[qsel];
  wire q_full = (q_used[qsel] == QDEPTH);
  wire [8:0] burst = opt[`CSC_OPT_BURST];
  wire is_init_ctrl = (op == `CSC_OP_INIT_CTRL);
  wire is_init_wq = (op == `CSC_OP_INIT_WQ);
  wire is_xfer = (op == `CSC_OP_SCSI) || (op == `CSC_OP_SCSI_SG);
  wire known = is_init_ctrl || is_init_wq || is_xfer || (op == `CSC_OP_BUS_RST) ||
               (op == `CSC_OP_TAG_SRCH) || (op == `CSC_OP_FLUSH);
  wire [3:0] tag = opt[`CSC_OPT_TAG];
  wire [15:0] moved = exec[31:16];

  // ----------------------------------------
  // Code selection, priority top to bottom
  // ----------------------------------------
  always @* begin
    next_code = `CSC_GOOD;
    if (!seen_first && !is_init_ctrl)
      next_code = `CSC_FIRST_CMD;
    else if (opt[`CSC_OPT_START_QM] && !ctrl_init && !is_init_ctrl)
      next_code = `CSC_QMODE_NRDY;
    else if (cmd[`CSC_CMD_RESV] != 4'h0)
      next_code = `CSC_RESV;
    else if (ctype != `CSC_TYPE_SCSI && ctype != `CSC_TYPE_CTRL)
      next_code = `CSC_CMD_CODE;
    else if (op == `CSC_OP_COMPLETE || !known)
      next_code = `CSC_CMD_UNAVAIL;
    else if (is_init_ctrl && (burst[0] || burst > `CSC_MAX_BURST))
      next_code = `CSC_BURST;
    else if (!is_init_ctrl && !qok)
      next_code = `CSC_QNUM;
    else if (is_init_wq && q_is_init && !opt[`CSC_OPT_REINIT])
      next_code = `CSC_Q_ALREADY;
    else if (!is_init_ctrl && !is_init_wq && !q_is_init)
      next_code = (ctype == `CSC_TYPE_SCSI) ? `CSC_Q_UNINIT : `CSC_WQ_INIT_ERR;
    else if (is_xfer && q_full)
      next_code = `CSC_QFULL;
    else if (exec[0])
      next_code = `CSC_FETCH_BERR;
    else if (exec[1])
      next_code = `CSC_FETCH_TMO;
    else if (exec[2])
      next_code = `CSC_FETCH_ADDR;
    else if (cmd[`CSC_CMD_PORT] && !cfg[`CSC_CFG_PORT1])
      next_code = `CSC_PORT1_NA;
    else if (is_xfer && cmd[`CSC_CMD_TGT] == cfg[`CSC_CFG_OWN_ID])
      next_code = `CSC_ID_ERR;
    else if (op == `CSC_OP_TAG_SRCH && tag == 4'h0)
      next_code = `CSC_TAG_ZERO;
    else if (op == `CSC_OP_TAG_SRCH && active_valid && tag == active_tag)
      next_code = `CSC_TAG_BUSY;
    else if (is_xfer && (opt[`CSC_OPT_MEMTYPE] > `CSC_MAX_MEMTYPE))
      next_code = `CSC_MEMTYPE;
    else if (is_xfer && (buf_addr[0] || (opt[`CSC_OPT_W32] && buf_addr[1])))
      next_code = `CSC_ADDR_ALIGN;
    else if (is_xfer && max_count[0])
      next_code = `CSC_ODD_COUNT;
    else if (op == `CSC_OP_SCSI_SG && (sg_count == 8'h00 || sg_count > `CSC_SG_MAX))
      next_code = `CSC_SG_COUNT;
    else if (exec[3])
      next_code = `CSC_BUS_IN_RST;
    else if (op == `CSC_OP_BUS_RST)
      next_code = `CSC_RST_DONE;
    else if (exec[4])
      next_code = `CSC_ABORT_RST;
    else if (exec[5])
      next_code = `CSC_SG_BERR;
    else if (exec[6])
      next_code = `CSC_SG_TMO;
    else if (exec[7])
      next_code = `CSC_ACQ_TMO;
    else if (exec[8])
      next_code = `CSC_DMA_BERR;
    else if (exec[9])
      next_code = `CSC_SEL_TMO;
    else if (exec[10])
      next_code = `CSC_DISC_TMO;
    else if (exec[11])
      next_code = `CSC_PARITY;
    else if (exec[12])
      next_code = `CSC_ABN_SEQ;
    else if (exec[13])
      next_code = `CSC_DISC_ERR;
    else if (is_xfer && {16'h0000, moved} != max_count)
      next_code = `CSC_XFER_CNT;
    else if (exec[14])
      next_code = `CSC_POST_BERR;
    else if (exec[15])
      next_code = `CSC_POST_TMO;
    else if (cfg[`CSC_CFG_POST_BAD])
      next_code = `CSC_POST_ADDR;
  end

  // ----------------------------------------
  // APB slave and command state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= 32'h0000_0000;
      opt <= 32'h0000_0000;
      buf_addr <= 32'h0000_0000;
      max_count <= 32'h0000_0000;
      sg_count <= 8'h00;
      cfg <= 5'h00;
      exec <= 32'h0000_0000;
      code <= 8'h00;
      pass_back <= 8'h00;
      done <= 1'b0;
      ctrl_init <= 1'b0;
      seen_first <= 1'b0;
      q_init <= {NQUEUE{1'b0}};
      for (i = 0; i < NQUEUE; i = i + 1)
        q_used[i] <= 3'h0;
      active_tag <= 4'h0;
      active_valid <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      scsi_bus_reset <= 1'b0;
    end else begin
      pready <= psel & ~pready;
      pslverr <= 1'b0;
      scsi_bus_reset <= 1'b0;
      if (psel && !pready && paddr > `CSC_A_XFER)
        pslverr <= 1'b1;
      if (apb_rd && !pready) begin
        case (paddr)
          `CSC_A_CMD: prdata <= cmd;
          `CSC_A_OPT: prdata <= opt;
          `CSC_A_ADDR: prdata <= buf_addr;
          `CSC_A_COUNT: prdata <= max_count;
          `CSC_A_SG: prdata <= {24'h000000, sg_count};
          `CSC_A_CFG: prdata <= {27'h0000000, cfg};
          `CSC_A_EXEC: prdata <= exec;
          `CSC_A_STAT: prdata <= {15'h0000, done, pass_back, code};
          `CSC_A_QSTAT: prdata <= {14'h0000, ctrl_init, seen_first, 1'b0, q_init};
          `CSC_A_XFER: prdata <= max_count;
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (apb_wr) begin
        case (paddr)
          `CSC_A_CMD: cmd <= pwdata;
          `CSC_A_OPT: opt <= pwdata;
          `CSC_A_ADDR: buf_addr <= pwdata;
          `CSC_A_COUNT: max_count <= pwdata;
          `CSC_A_SG: sg_count <= pwdata[7:0];
          `CSC_A_CFG: cfg <= pwdata[4:0];
          `CSC_A_EXEC: exec <= pwdata;
          default: ;
        endcase
      end
      if (go) begin
        code <= next_code;
        done <= 1'b1;
        seen_first <= 1'b1;
        pass_back <= (next_code == `CSC_GOOD) ? pwdata[7:0] : 8'h00;
        if (next_code == `CSC_GOOD || next_code == `CSC_XFER_CNT ||
            next_code == `CSC_RST_DONE) begin
          if (is_init_ctrl)
            ctrl_init <= 1'b1;
          if (is_init_wq) begin
            q_init[qsel] <= 1'b1;
            q_used[qsel] <= 3'h0;
          end
          if (op == `CSC_OP_FLUSH)
            q_used[qsel] <= 3'h0;
          if (op == `CSC_OP_BUS_RST)
            scsi_bus_reset <= 1'b1;
          if (is_xfer && exec[`CSC_EXEC_BITS + 1 - 1] == 1'b0) begin
            active_tag <= tag;
            active_valid <= 1'b1;
          end
        end
        if (next_code == `CSC_XFER_CNT)
          max_count <= {16'h0000, moved};
        if (is_xfer && known && (next_code != `CSC_QFULL) && qok && q_is_init &&
            (next_code == `CSC_GOOD || next_code == `CSC_XFER_CNT) && q_used[qsel] != 3'h0)
          q_used[qsel] <= q_used[qsel] - 3'h1;
      end else if (apb_wr && paddr == `CSC_A_QSTAT && qok && q_is_init && !q_full) begin
        q_used[qsel] <= q_used[qsel] + 3'h1;
      end else if (apb_wr && paddr == `CSC_A_STAT) begin
        done <= 1'b0;
        active_valid <= 1'b0;
      end
    end
  end

endmodule // csc_checker

// *** test/csc_checker_sva.sv ***
// Assertions on the APB ports and bus-reset output of the command status checker.
// Assumes a single pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/100ps
module csc_checker_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scsi_bus_reset
);
  reg [7:0] last_op;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op <= 8'h00;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      last_op <= pwdata[7:0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_wait; psel && !penable |=> pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_err_map; pready && paddr > 12'h028 |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_ok_map; pready && paddr <= 12'h028 |-> !pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
  property p_rd_hold; !$stable(prdata) |-> pready && !pwrite; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rst_pulse; scsi_bus_reset |=> !scsi_bus_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("bus reset pulse long");
  property p_rst_cause; scsi_bus_reset |-> last_op == 8'h22; endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("bus reset without command");
  c_rst: cover property (scsi_bus_reset);
  c_err: cover property (pready && pslverr);
  c_rd: cover property (pready && !pwrite && paddr == 12'h020);
endmodule // csc_checker_sva

bind csc_checker csc_checker_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scsi_bus_reset(scsi_bus_reset));

// *** test/csc_host_model.sv ***
// Host model: APB master standing in for the processor that issues parameter blocks.
// Assumes tasks are entered just after a rising pclk edge.
`timescale 1ns/100ps
module csc_host_model (
  input wire pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Released address and data are inverted so stale values never look valid
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // csc_host_model

// *** test/tb_top.sv ***
// Testbench: drives parameter blocks through the APB host model and checks completion codes.
// Assumes csc_checker with the register map of csc_defines.vh.
`timescale 1ns/100ps
`include "csc_defines.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, scsi_bus_reset;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int num_errors = 0;
  int comparisons = 0;
  int pulses = 0;
  logic [31:0] q;
  logic e;
  logic [31:0] sc;
  logic [7:0] ec [16] = '{`CSC_FETCH_BERR, `CSC_FETCH_TMO, `CSC_FETCH_ADDR, `CSC_BUS_IN_RST,
    `CSC_ABORT_RST, `CSC_SG_BERR, `CSC_SG_TMO, `CSC_ACQ_TMO, `CSC_DMA_BERR, `CSC_SEL_TMO,
    `CSC_DISC_TMO, `CSC_PARITY, `CSC_ABN_SEQ, `CSC_DISC_ERR, `CSC_POST_BERR, `CSC_POST_TMO};
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (scsi_bus_reset === 1'b1) pulses++;
  csc_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scsi_bus_reset(scsi_bus_reset));
  csc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function logic [31:0] c(input logic [7:0] op, input logic [1:0] ty, input logic [3:0] qn);
    c = {16'h0, qn, 2'h0, ty, op};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  // One parameter block: fields, outcome, go, then status read and done cleared
  task run(input logic [31:0] cmd, input logic [31:0] opt, input logic [31:0] ex,
           input logic [7:0] code);
    wr(`CSC_A_CMD, cmd);
    wr(`CSC_A_OPT, opt);
    wr(`CSC_A_EXEC, ex);
    wr(`CSC_A_GO, 32'h5A);
    host.xfer(1'b0, `CSC_A_STAT, 32'h0, q, e);
    chk({15'h0, q[16], 8'h0, q[7:0]}, {15'h0, 1'b1, 8'h0, code});
    wr(`CSC_A_STAT, 32'h0);
  endtask
  task restart;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(`CSC_A_ADDR, 32'h0);
    wr(`CSC_A_COUNT, 32'h10);
    wr(`CSC_A_SG, 32'h1);
    wr(`CSC_A_CFG, 32'h7);
  endtask
  task summarize;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial begin
    sc = c(`CSC_OP_SCSI_SG, `CSC_TYPE_SCSI, 4'h3);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    restart();
    run(sc, 32'h0, 32'h0010_0000, `CSC_FIRST_CMD);
    run(sc, 32'h2, 32'h0010_0000, `CSC_QMODE_NRDY);
    restart();
    run(c(`CSC_OP_INIT_CTRL, `CSC_TYPE_CTRL, 4'h0), 32'h0003_0000, 32'h0, `CSC_BURST);
    run(c(`CSC_OP_INIT_CTRL, `CSC_TYPE_CTRL, 4'h0), 32'h0102_0000, 32'h0, `CSC_BURST);
    run(c(`CSC_OP_INIT_CTRL, `CSC_TYPE_CTRL, 4'h0), 32'h0100_0000, 32'h0, `CSC_GOOD);
    run(c(`CSC_OP_SCSI, `CSC_TYPE_SCSI, 4'h5), 32'h0, 32'h0010_0000, `CSC_Q_UNINIT);
    run(c(`CSC_OP_FLUSH, `CSC_TYPE_CTRL, 4'h5), 32'h0, 32'h0, `CSC_WQ_INIT_ERR);
    run(c(`CSC_OP_INIT_WQ, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_GOOD);
    chk({24'h0, q[15:8]}, 32'h5A);
    run(c(`CSC_OP_INIT_WQ, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_Q_ALREADY);
    run(c(`CSC_OP_INIT_WQ, `CSC_TYPE_CTRL, 4'h3), 32'h1, 32'h0, `CSC_GOOD);
    run(c(`CSC_OP_INIT_WQ, `CSC_TYPE_CTRL, 4'hF), 32'h0, 32'h0, `CSC_QNUM);
    run(c(`CSC_OP_SCSI, 2'h3, 4'h3), 32'h0, 32'h0010_0000, `CSC_CMD_CODE);
    run(c(`CSC_OP_COMPLETE, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_CMD_UNAVAIL);
    run(sc | 32'h0010_0000, 32'h0, 32'h0011_0800, `CSC_RESV);
    run(c(`CSC_OP_BUS_RST, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_RST_DONE);
    chk(pulses, 1);
    run(sc | 32'h0008_0000, 32'h0, 32'h0010_0000, `CSC_PORT1_NA);
    run(sc | 32'h0007_0000, 32'h0, 32'h0010_0000, `CSC_ID_ERR);
    run(c(`CSC_OP_TAG_SRCH, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_TAG_ZERO);
    run(sc, 32'h0000_0040, 32'h0010_0000, `CSC_MEMTYPE);
    wr(`CSC_A_ADDR, 32'h1);
    run(sc, 32'h0, 32'h0010_0000, `CSC_ADDR_ALIGN);
    wr(`CSC_A_ADDR, 32'h2);
    run(sc, 32'h0000_0004, 32'h0010_0000, `CSC_ADDR_ALIGN);
    wr(`CSC_A_ADDR, 32'h0);
    wr(`CSC_A_COUNT, 32'h11);
    run(sc, 32'h0, 32'h0011_0000, `CSC_ODD_COUNT);
    wr(`CSC_A_COUNT, 32'h10);
    wr(`CSC_A_SG, 32'h41);
    run(sc, 32'h0, 32'h0010_0000, `CSC_SG_COUNT);
    wr(`CSC_A_SG, 32'h0);
    run(sc, 32'h0, 32'h0010_0000, `CSC_SG_COUNT);
    wr(`CSC_A_SG, 32'h1);
    for (int i = 0; i < 16; i++)
      run(sc, 32'h0, 32'h0010_0000 | (32'h1 << i), ec[i]);
    wr(`CSC_A_CFG, 32'h17);
    run(sc, 32'h0, 32'h0010_0000, `CSC_POST_ADDR);
    wr(`CSC_A_CFG, 32'h7);
    run(sc, 32'h0, 32'h0008_0000, `CSC_XFER_CNT);
    host.xfer(1'b0, `CSC_A_XFER, 32'h0, q, e);
    chk(q, 32'h8);
    repeat (4) wr(`CSC_A_QSTAT, 32'h0);
    run(sc, 32'h0, 32'h0010_0000, `CSC_QFULL);
    run(c(`CSC_OP_FLUSH, `CSC_TYPE_CTRL, 4'h3), 32'h0, 32'h0, `CSC_GOOD);
    run(sc, 32'h5000_0000, 32'h0008_0000, `CSC_GOOD);
    // Reissue without clearing status so the command stays active
    wr(`CSC_A_GO, 32'h5A);
    wr(`CSC_A_CMD, c(`CSC_OP_TAG_SRCH, `CSC_TYPE_CTRL, 4'h3));
    wr(`CSC_A_GO, 32'h5A);
    host.xfer(1'b0, `CSC_A_STAT, 32'h0, q, e);
    chk({24'h0, q[7:0]}, {24'h0, `CSC_TAG_BUSY});
    wr(`CSC_A_STAT, 32'h0);
    host.xfer(1'b0, 12'h02C, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    summarize();
  end
endmodule // tb_top
